// File: rtl/nand_ecc_dev.sv
`timescale 1ns/1ps
// Operation
// - correction enabled after reset
// - host sends feature write 1fh with value
// - enable bit one on, zero off
// - program computes parity over page first
// - read copies page, recomputes, compares parity
// - single bit errors repaired inside cache
// - fetch returns cache bytes, repaired only while enabled
// - status updated after each corrected read
// - main 000h-7ffh in four 512-byte segments
// - last twelve bytes of each spare protected
// - first four bytes per spare unprotected
// - parity lives in 840h through 87fh
// - parity region reserved while enabled
// - disabled: spare free for user data
// - byte 800h kept for bad block mark
module nand_ecc_dev
	import nand_ecc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link to the host
	nand_link_if.device link
);

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,   // waiting for a command
		S_ENC  = 8'h02,   // walking protected bytes for program
		S_PUT  = 8'h04,   // writing parity bytes into the cache
		S_OUT  = 8'h08,   // cache to array copy
		S_IN   = 8'h10,   // array to cache copy
		S_DEC  = 8'h20,   // walking protected and stored bytes
		S_FIX  = 8'h40,   // decide and repair one segment
		S_DONE = 8'h80    // answer and drop busy
	} state_type;

	// storage
	logic [7:0]       cache_mem [PAGE_BYTES];          // page buffer
	logic [7:0]       flash_mem [PAGES][PAGE_BYTES];   // array, no reset as in a real memory

	// state registers and their next values
	state_type        state_ff,   nxt_state;
	logic [SEG_W-1:0] seg_ff,     nxt_seg;             // segment being coded
	logic [IDX_W-1:0] idx_ff,     nxt_idx;             // byte step inside the segment
	logic [COL_W-1:0] col_ff,     nxt_col;             // copy column or fetch column
	logic [PAGE_W-1:0] page_ff,   nxt_page;            // target page
	logic [SYN_W-1:0] syn_ff,     nxt_syn;             // running syndrome
	logic             par_ff,     nxt_par;             // running overall parity
	logic             fixed_ff,   nxt_fixed;           // some segment was repaired
	logic             fail_ff,    nxt_fail;            // some segment could not be repaired
	logic             is_rd_ff,   nxt_is_rd;           // current job is a fetch
	logic             busy_ff,    nxt_busy;
	logic             rsp_v_ff,   nxt_rsp_v;
	logic [7:0]       rsp_d_ff,   nxt_rsp_d;
	logic [1:0]       stat_ff,    nxt_stat;
	logic             ecc_en_ff,  nxt_ecc_en;

	// memory ports
	logic             cache_we;
	logic [COL_W-1:0] cache_wa;
	logic [7:0]       cache_wd;
	logic             flash_we;
	logic [COL_W-1:0] rd_addr;
	logic [7:0]       cache_q;
	logic [SYN_W-1:0] err_pos;                         // failing bit index, syndrome minus one

	// byte address of protected step k of segment s, parity bytes follow the data
	function automatic logic [COL_W-1:0] prot_addr(input logic [SEG_W-1:0] s, input logic [IDX_W-1:0] k);
		logic [COL_W-1:0] sp;
		sp = SPARE_STEP * COL_W'(s);
		if (k < IDX_W'(MAIN_SEG))
			prot_addr = COL_W'(MAIN_SEG) * COL_W'(s) + COL_W'(k);
		else if (k < IDX_W'(PROT_BYTES))
			prot_addr = META_OFS + sp + COL_W'(k) - COL_W'(MAIN_SEG);
		else
			prot_addr = PAR_OFS + sp + COL_W'(k) - COL_W'(PROT_BYTES);
	endfunction

	// syndrome contribution of one data byte: xor of one-based bit positions
	function automatic logic [SYN_W:0] byte_syn(input logic [IDX_W-1:0] k, input logic [7:0] d);
		logic [SYN_W-1:0] s;
		logic             p;
		s = '0;
		p = 1'b0;
		for (int b = 0; b < 8; b++) begin
			if (d[b]) begin
				s = s ^ (SYN_W'(k) * SYN_W'(8) + SYN_W'(b) + SYN_W'(1));
				p = ~p;
			end
		end
		byte_syn = {p, s};
	endfunction

	assign link.busy       = busy_ff;
	assign link.rsp_valid  = rsp_v_ff;
	assign link.rsp_data   = rsp_d_ff;
	assign link.ecc_status = stat_ff;
	assign link.ecc_en     = ecc_en_ff;
	assign err_pos         = syn_ff - SYN_W'(1);
	assign cache_q         = cache_mem[rd_addr];

	//////////////////////////////////////////////////////////////////////////////////////////////
	// read address of the cache, shared by coding, repair and fetch
	always_comb begin
		case (state_ff)
			S_ENC, S_DEC: rd_addr = prot_addr(seg_ff, idx_ff);
			S_FIX:        rd_addr = prot_addr(seg_ff, err_pos[SYN_W-1:3]);
			default:      rd_addr = col_ff;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// next state, counters, memory strobes and link answers
	always_comb begin
		nxt_state  = state_ff;
		nxt_seg    = seg_ff;
		nxt_idx    = idx_ff;
		nxt_col    = col_ff;
		nxt_page   = page_ff;
		nxt_syn    = syn_ff;
		nxt_par    = par_ff;
		nxt_fixed  = fixed_ff;
		nxt_fail   = fail_ff;
		nxt_is_rd  = is_rd_ff;
		nxt_busy   = busy_ff;
		nxt_rsp_v  = 1'b0;
		nxt_rsp_d  = rsp_d_ff;
		nxt_stat   = stat_ff;
		nxt_ecc_en = ecc_en_ff;
		cache_we   = 1'b0;
		cache_wa   = col_ff;
		cache_wd   = link.cmd_data;
		flash_we   = 1'b0;
		case (state_ff)
			S_IDLE: begin
				// commands are only taken while idle, so a fetch never sees a half-done page
				if (link.cmd_valid) begin
					nxt_busy  = 1'b1;
					nxt_state = S_DONE;
					nxt_is_rd = 1'b0;
					nxt_col   = link.cmd_addr;
					nxt_seg   = '0;
					nxt_idx   = '0;
					nxt_syn   = '0;
					nxt_par   = 1'b0;
					nxt_page  = link.cmd_addr[PAGE_W-1:0];
					case (link.cmd_op)
						OP_SET_FEAT: nxt_ecc_en = link.cmd_data[ECC_EN_BIT];
						OP_LOAD: begin
							// parity region is write protected while correction is on
							cache_wa = link.cmd_addr;
							cache_we = !(ecc_en_ff && link.cmd_addr >= PAR_OFS &&
							             link.cmd_addr <= PAR_END);
						end
						OP_PROGRAM: begin
							nxt_col   = '0;
							nxt_state = ecc_en_ff ? S_ENC : S_OUT;
						end
						OP_PAGE_READ: begin
							nxt_col   = '0;
							nxt_fixed = 1'b0;
							nxt_fail  = 1'b0;
							nxt_state = S_IN;
						end
						OP_FETCH: nxt_is_rd = 1'b1;
						default:  nxt_state = S_DONE;                                      // unknown opcode is a no-op
					endcase
				end
			end
			S_ENC: begin
				{nxt_par, nxt_syn} = {par_ff, syn_ff} ^ byte_syn(idx_ff, cache_q);
				nxt_idx = idx_ff + IDX_W'(1);
				if (idx_ff == IDX_W'(PROT_BYTES - 1)) begin
					nxt_idx   = '0;
					nxt_state = S_PUT;
				end
			end
			S_PUT: begin
				// three of the sixteen parity bytes per segment carry the code
				cache_we = 1'b1;
				cache_wa = prot_addr(seg_ff, idx_ff + IDX_W'(PROT_BYTES));
				case (idx_ff[1:0])
					2'h0:    cache_wd = syn_ff[7:0];
					2'h1:    cache_wd = 8'(syn_ff[SYN_W-1:8]);
					default: cache_wd = {7'h00, par_ff};
				endcase
				nxt_idx = idx_ff + IDX_W'(1);
				if (idx_ff == IDX_W'(PAR_USED - 1)) begin
					nxt_idx = '0;
					nxt_syn = '0;
					nxt_par = 1'b0;
					nxt_seg = seg_ff + SEG_W'(1);
					if (seg_ff == SEG_W'(SEGS - 1))
						nxt_state = S_OUT;
					else
						nxt_state = S_ENC;
				end
			end
			S_OUT: begin
				flash_we = 1'b1;
				nxt_col  = col_ff + COL_W'(1);
				if (col_ff == COL_W'(PAGE_BYTES - 1))
					nxt_state = S_DONE;
			end
			S_IN: begin
				cache_we = 1'b1;
				cache_wd = flash_mem[page_ff][col_ff];
				nxt_col  = col_ff + COL_W'(1);
				if (col_ff == COL_W'(PAGE_BYTES - 1)) begin
					nxt_state = ecc_en_ff ? S_DEC : S_DONE;
					if (!ecc_en_ff)
						nxt_stat = ST_CLEAN;
				end
			end
			S_DEC: begin
				// the stored code is folded into the sum, a clean segment leaves zero
				if (idx_ff < IDX_W'(PROT_BYTES))
					{nxt_par, nxt_syn} = {par_ff, syn_ff} ^ byte_syn(idx_ff, cache_q);
				else if (idx_ff == IDX_W'(PROT_BYTES))
					nxt_syn = syn_ff ^ SYN_W'(cache_q);
				else if (idx_ff == IDX_W'(DEC_LAST))
					nxt_par = par_ff ^ cache_q[0];
				else
					nxt_syn = syn_ff ^ {cache_q[SYN_W-9:0], 8'h00};
				nxt_idx = idx_ff + IDX_W'(1);
				if (idx_ff == IDX_W'(DEC_LAST))
					nxt_state = S_FIX;
			end
			S_FIX: begin
				// single bit errors are fixed; a flipped syndrome bit with clean data reads as a failure, a flipped parity bit reads clean
				if (par_ff && syn_ff != '0 && syn_ff <= SYN_MAX) begin
					cache_we  = 1'b1;
					cache_wa  = rd_addr;
					cache_wd  = cache_q ^ (8'h01 << err_pos[2:0]);
					nxt_fixed = 1'b1;
				end else if (syn_ff != '0) begin
					nxt_fail  = 1'b1;
				end
				nxt_idx = '0;
				nxt_syn = '0;
				nxt_par = 1'b0;
				nxt_seg = seg_ff + SEG_W'(1);
				nxt_state = S_DEC;
				if (seg_ff == SEG_W'(SEGS - 1)) begin
					nxt_state = S_DONE;
					if (nxt_fail)
						nxt_stat = ST_FAIL;
					else if (nxt_fixed)
						nxt_stat = ST_FIXED;
					else
						nxt_stat = ST_CLEAN;
				end
			end
			S_DONE: begin
				nxt_busy  = 1'b0;
				nxt_rsp_v = is_rd_ff;
				nxt_rsp_d = cache_q;
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_busy  = 1'b0;
				nxt_state = S_IDLE;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff  <= S_IDLE;
			seg_ff    <= '0;
			idx_ff    <= '0;
			col_ff    <= '0;
			page_ff   <= '0;
			syn_ff    <= '0;
			par_ff    <= 1'b0;
			fixed_ff  <= 1'b0;
			fail_ff   <= 1'b0;
			is_rd_ff  <= 1'b0;
			busy_ff   <= 1'b0;
			rsp_v_ff  <= 1'b0;
			rsp_d_ff  <= 8'h00;
			stat_ff   <= ST_CLEAN;
			ecc_en_ff <= ECC_EN_RST;
		end else begin
			state_ff  <= nxt_state;
			seg_ff    <= nxt_seg;
			idx_ff    <= nxt_idx;
			col_ff    <= nxt_col;
			page_ff   <= nxt_page;
			syn_ff    <= nxt_syn;
			par_ff    <= nxt_par;
			fixed_ff  <= nxt_fixed;
			fail_ff   <= nxt_fail;
			is_rd_ff  <= nxt_is_rd;
			busy_ff   <= nxt_busy;
			rsp_v_ff  <= nxt_rsp_v;
			rsp_d_ff  <= nxt_rsp_d;
			stat_ff   <= nxt_stat;
			ecc_en_ff <= nxt_ecc_en;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// memory writes; the bad block byte is never touched by coding, only by host loads and page reads
	always_ff @(posedge clk) begin
		if (cache_we)
			cache_mem[cache_wa] <= cache_wd;
		if (flash_we)
			flash_mem[page_ff][col_ff] <= cache_mem[col_ff];
	end

endmodule

// File: rtl/nand_ecc_pkg.sv
package nand_ecc_pkg;
	// page geometry
	localparam int         PAGE_BYTES   = 2176;          // main plus spare bytes held in the cache
	localparam int         PAGES        = 4;             // pages modelled in the array
	localparam int         PAGE_W       = 2;             // width of a page index
	localparam int         COL_W        = 12;            // width of a column address
	localparam int         SEGS         = 4;             // protected segments per page
	localparam int         SEG_W        = 2;             // width of a segment index
	localparam int         IDX_W        = 10;            // width of the byte walk counter
	localparam int         SYN_W        = 13;            // width of a syndrome

	// protection map
	localparam int         MAIN_SEG     = 512;           // main bytes per segment, 000h..7ffh in four
	localparam int         META_BYTES   = 12;            // protected metadata bytes per spare section
	localparam int         PROT_BYTES   = 524;           // protected bytes per segment
	localparam int         DEC_LAST     = 526;           // last decode step, reading the stored parity
	localparam logic [11:0] META_OFS    = 12'h804;       // first protected metadata byte of spare 0
	localparam logic [11:0] SPARE_STEP  = 12'h010;       // stride between spare sections
	localparam logic [11:0] PAR_OFS     = 12'h840;       // parity region start
	localparam logic [11:0] PAR_END     = 12'h87f;       // parity region end
	localparam logic [11:0] BAD_MARK    = 12'h800;       // bad block marker column
	localparam int         PAR_USED     = 3;             // parity bytes written per segment
	localparam logic [12:0] SYN_MAX     = 13'h1060;      // largest valid syndrome, 524 bytes * 8 bits

	// link opcodes
	localparam logic [7:0] OP_SET_FEAT  = 8'h1f;         // feature write
	localparam logic [7:0] OP_LOAD      = 8'h02;         // load one cache byte
	localparam logic [7:0] OP_PROGRAM   = 8'h10;         // program cache into a page
	localparam logic [7:0] OP_PAGE_READ = 8'h13;         // move a page into the cache
	localparam logic [7:0] OP_FETCH     = 8'h03;         // read one cache byte
	localparam int         ECC_EN_BIT   = 4;             // position of the correction enable bit
	localparam logic       ECC_EN_RST   = 1'b1;          // correction is on after reset

	// correction status codes
	localparam logic [1:0] ST_CLEAN     = 2'h0;          // no error seen
	localparam logic [1:0] ST_FIXED     = 2'h1;          // errors corrected
	localparam logic [1:0] ST_FAIL      = 2'h2;          // uncorrectable

	// user side operations of the host end
	localparam logic [2:0] UOP_FEATURE  = 3'h0;
	localparam logic [2:0] UOP_LOAD     = 3'h1;
	localparam logic [2:0] UOP_PROGRAM  = 3'h2;
	localparam logic [2:0] UOP_READ     = 3'h3;
	localparam logic [2:0] UOP_FETCH    = 3'h4;
endpackage

// File: rtl/nand_link_if.sv
`timescale 1ns/1ps
interface nand_link_if;
	import nand_ecc_pkg::*;
	logic             cmd_valid;   // host: one cycle command strobe
	logic [7:0]       cmd_op;      // host: opcode
	logic [COL_W-1:0] cmd_addr;    // host: column, or page index in low bits
	logic [7:0]       cmd_data;    // host: data byte
	logic             busy;        // device: command in progress
	logic             rsp_valid;   // device: one cycle fetch answer
	logic [7:0]       rsp_data;    // device: fetched byte
	logic [1:0]       ecc_status;  // device: status of last page read
	logic             ecc_en;      // device: current correction enable

	modport device (input cmd_valid, cmd_op, cmd_addr, cmd_data,
	                output busy, rsp_valid, rsp_data, ecc_status, ecc_en);
	modport host   (output cmd_valid, cmd_op, cmd_addr, cmd_data,
	                input busy, rsp_valid, rsp_data, ecc_status, ecc_en);
endinterface

// File: rtl/nand_ecc_host.sv
`timescale 1ns/1ps
module nand_ecc_host
	import nand_ecc_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// user requests
	input  wire logic             usr_req,
	input  wire logic [2:0]       usr_op,
	input  wire logic [COL_W-1:0] usr_addr,
	input  wire logic [7:0]       usr_data,
	// user answers
	output logic                  usr_ready,
	output logic                  usr_done,
	output logic                  usr_refused,
	output logic [7:0]            usr_rdata,
	output logic [1:0]            usr_status,
	// link to the device
	nand_link_if.host             link
);

	typedef enum logic [2:0] {
		H_IDLE = 3'h1,   // ready for a user request
		H_SEND = 3'h2,   // command strobe on the link
		H_WAIT = 3'h4    // device busy
	} hstate_type;

	hstate_type       state_ff, nxt_state;
	logic             ecc_on_ff, nxt_ecc_on;     // mirror of the enable bit sent last
	logic             cv_ff,    nxt_cv;
	logic [7:0]       op_ff,    nxt_op;
	logic [COL_W-1:0] addr_ff,  nxt_addr;
	logic [7:0]       data_ff,  nxt_data;
	logic             rdy_ff,   nxt_rdy;
	logic             done_ff,  nxt_done;
	logic             ref_ff,   nxt_ref;
	logic [7:0]       rdat_ff,  nxt_rdat;
	logic [1:0]       stat_ff,  nxt_stat;

	assign link.cmd_valid = cv_ff;
	assign link.cmd_op    = op_ff;
	assign link.cmd_addr  = addr_ff;
	assign link.cmd_data  = data_ff;
	assign usr_ready      = rdy_ff;
	assign usr_done       = done_ff;
	assign usr_refused    = ref_ff;
	assign usr_rdata      = rdat_ff;
	assign usr_status     = stat_ff;

	//////////////////////////////////////////////////////////////////////////////////////////////
	// request translation and busy tracking
	always_comb begin
		nxt_state  = state_ff;
		nxt_ecc_on = ecc_on_ff;
		nxt_cv     = 1'b0;
		nxt_op     = op_ff;
		nxt_addr   = addr_ff;
		nxt_data   = data_ff;
		nxt_rdy    = rdy_ff;
		nxt_done   = 1'b0;
		nxt_ref    = 1'b0;
		nxt_rdat   = rdat_ff;
		nxt_stat   = stat_ff;
		case (state_ff)
			H_IDLE: begin
				if (usr_req) begin
					nxt_addr  = usr_addr;
					nxt_data  = usr_data;
					nxt_cv    = 1'b1;
					nxt_rdy   = 1'b0;
					nxt_state = H_SEND;
					case (usr_op)
						UOP_FEATURE: begin
							nxt_op     = OP_SET_FEAT;
							nxt_data   = 8'(usr_data[0]) << ECC_EN_BIT;
							nxt_ecc_on = usr_data[0];
						end
						UOP_LOAD:    nxt_op = OP_LOAD;
						UOP_PROGRAM: nxt_op = OP_PROGRAM;
						UOP_READ:    nxt_op = OP_PAGE_READ;
						default:     nxt_op = OP_FETCH;
					endcase
					// keep user data off the marker byte, and off the parity area while coding is on
					if (usr_op == UOP_LOAD && (usr_addr == BAD_MARK ||
					    (ecc_on_ff && usr_addr >= PAR_OFS && usr_addr <= PAR_END))) begin
						nxt_cv    = 1'b0;
						nxt_ref   = 1'b1;
						nxt_rdy   = 1'b1;
						nxt_state = H_IDLE;
					end
				end
			end
			H_SEND: nxt_state = H_WAIT;                  // device raises busy on this edge
			H_WAIT: begin
				if (link.rsp_valid)
					nxt_rdat = link.rsp_data;
				if (!link.busy) begin
					nxt_stat  = link.ecc_status;
					nxt_done  = 1'b1;
					nxt_rdy   = 1'b1;
					nxt_state = H_IDLE;
				end
			end
			default: nxt_state = H_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff  <= H_IDLE;
			ecc_on_ff <= ECC_EN_RST;
			cv_ff     <= 1'b0;
			op_ff     <= 8'h00;
			addr_ff   <= '0;
			data_ff   <= 8'h00;
			rdy_ff    <= 1'b1;
			done_ff   <= 1'b0;
			ref_ff    <= 1'b0;
			rdat_ff   <= 8'h00;
			stat_ff   <= ST_CLEAN;
		end else begin
			state_ff  <= nxt_state;
			ecc_on_ff <= nxt_ecc_on;
			cv_ff     <= nxt_cv;
			op_ff     <= nxt_op;
			addr_ff   <= nxt_addr;
			data_ff   <= nxt_data;
			rdy_ff    <= nxt_rdy;
			done_ff   <= nxt_done;
			ref_ff    <= nxt_ref;
			rdat_ff   <= nxt_rdat;
			stat_ff   <= nxt_stat;
		end
	end

endmodule

// File: verif/nand_ecc_properties.sv
`timescale 1ns/1ps
module nand_ecc_properties
	import nand_ecc_pkg::*;
(
	// clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// host strobes
	input wire logic             cmd_valid,
	input wire logic [7:0]       cmd_op,
	input wire logic [COL_W-1:0] cmd_addr,
	input wire logic [7:0]       cmd_data,
	// device answers
	input wire logic             busy,
	input wire logic             rsp_valid,
	input wire logic [7:0]       rsp_data,
	input wire logic [1:0]       ecc_status,
	input wire logic             ecc_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	logic        take;    // command accepted by an idle device
	logic [7:0]  lop_ff;  // opcode of the last accepted command
	logic        len_ff;  // enable state seen when it was accepted
	logic [12:0] cnt_ff;  // busy cycles of the running command
	assign take = cmd_valid && !busy;
	// capture each command and count its busy span
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lop_ff <= 8'h00;
			len_ff <= 1'b1;
			cnt_ff <= 13'h0000;
		end else if (take) begin
			lop_ff <= cmd_op;
			len_ff <= ecc_en;
			cnt_ff <= 13'h0000;
		end else if (busy) begin
			cnt_ff <= cnt_ff + 13'h0001;
		end
	end
	// busy length: parity work only when enabled, so a stuck enable shows here
	function automatic int blen(input logic [7:0] o, input logic e);
		if (o == OP_PROGRAM)
			return e ? SEGS * (PROT_BYTES + PAR_USED) + PAGE_BYTES + 1 : PAGE_BYTES + 1;
		if (o == OP_PAGE_READ)
			return e ? PAGE_BYTES + SEGS * (DEC_LAST + 2) + 1 : PAGE_BYTES + 1;
		return 1;
	endfunction
	property p_feat;
		logic v;
		(take && cmd_op == OP_SET_FEAT, v = cmd_data[ECC_EN_BIT]) |-> ##3 ecc_en == v;
	endproperty
	////////////////////////////////////////
	a_reset_enable: assert property ($fell(rst) |-> ecc_en)
		else $error("correction off after reset");
	a_feature_sets_enable: assert property (p_feat)
		else $error("enable bit not taken from feature write");
	a_enable_cause: assert property ($changed(ecc_en) |-> lop_ff == OP_SET_FEAT)
		else $error("enable moved without feature write");
	a_fetch_answer: assert property (take && cmd_op == OP_FETCH |=> busy ##1 (rsp_valid && !busy))
		else $error("fetch answer late or missing");
	a_rsp_cause: assert property (rsp_valid |-> lop_ff == OP_FETCH)
		else $error("data answer without fetch");
	a_busy_length: assert property ($fell(busy) |-> cnt_ff == 13'(blen(lop_ff, len_ff)))
		else $error("busy span wrong for command");
	a_status_cause: assert property ($changed(ecc_status) |-> lop_ff == OP_PAGE_READ)
		else $error("status moved without page read");
	a_status_when_off: assert property ($fell(busy) && lop_ff == OP_PAGE_READ && !len_ff
		|-> ##[0:1] ecc_status == ST_CLEAN)
		else $error("raw read left a correction status");
	c_prog_on: cover property (take && cmd_op == OP_PROGRAM && ecc_en);
	c_fixed: cover property (ecc_status == ST_FIXED);
	c_fail: cover property (ecc_status == ST_FAIL);
	c_disable: cover property (take && cmd_op == OP_SET_FEAT && !cmd_data[ECC_EN_BIT]);
endmodule

// File: verif/nand_page_internal_ecc_tb_top.sv
`timescale 1ns/1ps
module nand_page_internal_ecc_tb_top;
	import nand_ecc_pkg::*;
	logic             clk;         // 10 MHz
	logic             rst;         // async, active high
	logic             usr_req;     // request level
	logic [2:0]       usr_op;      // operation
	logic [COL_W-1:0] usr_addr;    // column or page
	logic [7:0]       usr_data;    // byte or enable
	logic             usr_ready;   // host idle
	logic             usr_done;    // completion pulse
	logic             usr_refused; // refusal pulse
	logic [7:0]       usr_rdata;   // last fetched byte
	logic [1:0]       usr_status;  // last read status
	int               failures;    // mismatches
	int               checks_done; // comparisons
	nand_link_if link();
	nand_ecc_dev i_nand_ecc_dev (.clk(clk), .rst(rst), .link(link));
	nand_ecc_host i_nand_ecc_host (.clk(clk), .rst(rst), .usr_req(usr_req), .usr_op(usr_op),
		.usr_addr(usr_addr), .usr_data(usr_data), .usr_ready(usr_ready), .usr_done(usr_done),
		.usr_refused(usr_refused), .usr_rdata(usr_rdata), .usr_status(usr_status), .link(link));
	nand_ecc_properties i_nand_ecc_properties (.clk(clk), .rst(rst), .cmd_valid(link.cmd_valid),
		.cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data), .busy(link.busy),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .ecc_status(link.ecc_status),
		.ecc_en(link.ecc_en));
	always #50 clk = ~clk;
	////////////////////////////////////////
	// fill pattern; byte 000h is 00h so flips are easy to read back
	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ {4'h0, a[11:8]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one user operation; a page command can take over 4000 cycles
	task automatic op(input logic [2:0] o, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		usr_op <= o;
		usr_addr <= a;
		usr_data <= d;
		usr_req <= 1'b1;
		@(posedge clk);
		usr_req <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (usr_done !== 1'b1 && usr_refused !== 1'b1 && n < 6000);
		if (n >= 6000) begin
			failures++;
			$display("Error at %0t: no completion", $time);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		@(negedge clk);
		chk(8'(link.ecc_en), 8'h01);
		chk(8'(usr_ready), 8'h01);
	endtask
	// load every protected byte; marker and parity columns must bounce
	task automatic t_fill;
		for (int a = 0; a < 32'h840; a++) begin
			op(UOP_LOAD, 12'(a), pat(12'(a)));
			chk(8'(usr_refused), 8'(a == 32'h800));
		end
		op(UOP_LOAD, 12'h840, 8'h55);
		chk(8'(usr_refused), 8'h01);
	endtask
	task automatic t_clean;
		logic [11:0] at [4] = '{12'h000, 12'h7ff, 12'h804, 12'h83f};
		op(UOP_PROGRAM, 12'h000, 8'h00);
		op(UOP_READ, 12'h000, 8'h00);
		chk(8'(usr_status), 8'(ST_CLEAN));
		foreach (at[i]) begin
			op(UOP_FETCH, at[i], 8'h00);
			chk(usr_rdata, pat(at[i]));
		end
	endtask
	// raw copy of page 0 with one flipped main bit goes to page 1
	// byte 802h loses two bits too: were it covered, segment 0 would still read as repaired, the fix flipping bit 6 of byte 000h
	task automatic t_single;
		op(UOP_FEATURE, 12'h000, 8'h00);
		chk(8'(link.ecc_en), 8'h00);
		op(UOP_READ, 12'h000, 8'h00);
		chk(8'(usr_status), 8'(ST_CLEAN));
		op(UOP_LOAD, 12'h000, 8'h01);
		op(UOP_LOAD, 12'h802, 8'h00);
		op(UOP_LOAD, 12'h87f, 8'h5a);
		chk(8'(usr_refused), 8'h00);
		op(UOP_PROGRAM, 12'h001, 8'h00);
		op(UOP_FEATURE, 12'h000, 8'h01);
		chk(8'(link.ecc_en), 8'h01);
		op(UOP_READ, 12'h001, 8'h00);
		chk(8'(usr_status), 8'(ST_FIXED));
		op(UOP_FETCH, 12'h000, 8'h00);
		chk(usr_rdata, 8'h00);
		op(UOP_FETCH, 12'h802, 8'h00);
		chk(usr_rdata, 8'h00);
		op(UOP_FETCH, 12'h87f, 8'h00);
		chk(usr_rdata, 8'h5a);
	endtask
	// raw read shows the flip and clears the old status; two flips cannot be repaired
	task automatic t_double;
		op(UOP_FEATURE, 12'h000, 8'h00);
		op(UOP_READ, 12'h001, 8'h00);
		chk(8'(usr_status), 8'(ST_CLEAN));
		op(UOP_FETCH, 12'h000, 8'h00);
		chk(usr_rdata, 8'h01);
		op(UOP_LOAD, 12'h000, 8'h03);
		op(UOP_PROGRAM, 12'h002, 8'h00);
		op(UOP_FEATURE, 12'h000, 8'h01);
		op(UOP_READ, 12'h002, 8'h00);
		chk(8'(usr_status), 8'(ST_FAIL));
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		usr_req = 1'b0;
		usr_op = 3'h0;
		usr_addr = 12'h000;
		usr_data = 8'h00;
		failures = 0;
		checks_done = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fill();
		t_clean();
		t_single();
		t_double();
		final_report();
	end
	// the run needs roughly 36500 cycles
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		final_report();
	end
endmodule
